// ==== pkg/flsw_pkg.sv ====
// constants and types shared by the flash status and suspend host controller
package flsw_pkg;
	localparam int CLK_MHZ = 250;
	// bus cycle timing in ns, suspend wait in us, and derived clock counts (least times round up)
	localparam int T_RC_NS   = 70;
	localparam int T_WP_NS   = 35;
	localparam int T_WPH_NS  = 20;
	localparam int T_OEH_NS  = 20;
	localparam int T_SUSP_US = 15;
	localparam int SYNC_CYC  = 2;
	localparam logic [11:0] RC_CYC   = 12'((T_RC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC);
	localparam logic [11:0] WP_CYC   = 12'((T_WP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] WPH_CYC  = 12'((T_WPH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OEH_CYC  = 12'((T_OEH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] SUSP_CYC = 12'(T_SUSP_US * CLK_MHZ);

	// register byte offsets of the controller
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA  = 8'h10;
	localparam logic [7:0] REG_ACCEL  = 8'h14;

	// flash status bit positions on the data bus
	localparam int BIT_DATA_POLL    = 7;
	localparam int BIT_TOGGLE_ONE   = 6;
	localparam int BIT_TIMEOUT      = 5;
	localparam int BIT_TOGGLE_TWO   = 2;
	localparam int BIT_BUFFER_ABORT = 1;

	// command codes and unlock addresses
	localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
	localparam logic [15:0] CMD_RESUME  = 16'h0030;
	localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
	localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [15:0] CMD_RESET   = 16'h00F0;
	localparam logic [22:0] ADR_UNLOCK1 = 23'h000555;
	localparam logic [22:0] ADR_UNLOCK2 = 23'h0002AA;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OP_NONE, OP_WRITE, OP_READ, OP_SUSPEND, OP_RESUME, OP_POLL, OP_RESET3
	} flsw_op_t;

	typedef enum {
		ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_RD_LOW, ST_RD_HIGH, ST_SUSP_WAIT
	} flsw_state_t;

	// flash-side pins driven by the controller
	typedef struct packed {
		logic [22:0] addr;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [15:0] dq;
		logic        dq_oe;
		logic        acc_hv;
	} flsw_pins_t;
endpackage : flsw_pkg

// ==== hw/flsw_host.sv ====
// host controller that drives a parallel nor flash for suspend, resume and status polling
`timescale 1ns/1ps

module flsw_host import flsw_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output flsw_pins_t       flash_o,
	input  wire logic [15:0] flash_dq_i
);
	flsw_state_t state;
	flsw_op_t    op;
	logic [11:0] cnt;
	logic [1:0]  step;
	logic [22:0] cyc_addr;
	logic [15:0] cyc_data;
	logic [22:0] op_addr;
	logic [15:0] op_wdata;
	logic [15:0] rdata;
	logic        accel_en;
	logic        done;
	logic        timed_out;
	logic        aborted;
	logic        toggle_two_seen;
	logic        poll_first;
	logic        poll_prev6;
	logic        poll_prev2;
	logic        dq5_seen;
	logic [15:0] dq_s1;
	logic [15:0] dq_s2;

	// axi write channel holding registers
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_fire;
	logic        start;
	flsw_op_t    start_op;

	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
	assign start_op = flsw_op_t'(w_data[2:0]);
	// orders written while busy are dropped; software checks busy first
	assign start = wr_fire && aw_addr == REG_CTRL && w_strb[0]
		&& state == ST_IDLE && start_op != OP_NONE;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			if (aw_addr == REG_CTRL || aw_addr == REG_ADDR || aw_addr == REG_WDATA
				|| aw_addr == REG_ACCEL || aw_addr == REG_STATUS
				|| aw_addr == REG_RDATA) begin
				s_axi_bresp_o <= RESP_OKAY;
			end else begin
				s_axi_bresp_o <= RESP_SLVERR;
			end
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			op_addr  <= 23'h000000;
			op_wdata <= 16'h0000;
			accel_en <= 1'b0;
		end else if (wr_fire) begin
			if (aw_addr == REG_ADDR) begin
				op_addr <= w_data[22:0];
			end else if (aw_addr == REG_WDATA) begin
				op_wdata <= w_data[15:0];
			end else if (aw_addr == REG_ACCEL && w_strb[0]) begin
				// software unlocks sectors first and raises this only to program
				accel_en <= w_data[0];
			end
		end
	end

	// axi read channel
	assign s_axi_arready_o = !s_axi_rvalid_o;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o  <= RESP_OKAY;
			if (s_axi_araddr_i == REG_CTRL) begin
				s_axi_rdata_o <= {29'h0, op};
			end else if (s_axi_araddr_i == REG_ADDR) begin
				s_axi_rdata_o <= {9'h000, op_addr};
			end else if (s_axi_araddr_i == REG_WDATA) begin
				s_axi_rdata_o <= {16'h0000, op_wdata};
			end else if (s_axi_araddr_i == REG_STATUS) begin
				s_axi_rdata_o <= {26'h0, rdata[BIT_DATA_POLL], toggle_two_seen,
					aborted, timed_out, done, state != ST_IDLE};
			end else if (s_axi_araddr_i == REG_RDATA) begin
				s_axi_rdata_o <= {16'h0000, rdata};
			end else if (s_axi_araddr_i == REG_ACCEL) begin
				s_axi_rdata_o <= {31'h0, accel_en};
			end else begin
				s_axi_rdata_o <= 32'h0000_0000;
				s_axi_rresp_o <= RESP_SLVERR;
			end
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// flash data pins are asynchronous to clk_i
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
		end else begin
			dq_s1 <= flash_dq_i;
			dq_s2 <= dq_s1;
		end
	end

	// bus cycle engine and command sequencer
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state    <= ST_IDLE;
			op       <= OP_NONE;
			cnt      <= 12'h000;
			step     <= 2'h0;
			cyc_addr <= 23'h000000;
			cyc_data <= 16'h0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start) begin
						op   <= start_op;
						step <= 2'h0;
						cnt  <= 12'h000;
						cyc_addr <= op_addr;
						case (start_op)
							OP_WRITE: begin
								cyc_data <= op_wdata;
								state    <= ST_WR_LOW;
							end
							OP_SUSPEND: begin
								cyc_data <= CMD_SUSPEND;
								state    <= ST_WR_LOW;
							end
							OP_RESUME: begin
								cyc_data <= CMD_RESUME;
								state    <= ST_WR_LOW;
							end
							OP_RESET3: begin
								cyc_addr <= ADR_UNLOCK1;
								cyc_data <= CMD_UNLOCK1;
								state    <= ST_WR_LOW;
							end
							default: begin
								// polls read at the program address, last loaded word
								state <= ST_RD_LOW;
							end
						endcase
					end
				end
				ST_WR_LOW: begin
					cnt <= cnt + 12'h001;
					if (cnt == WP_CYC - 12'h001) begin
						cnt   <= 12'h000;
						state <= ST_WR_HIGH;
					end
				end
				ST_WR_HIGH: begin
					cnt <= cnt + 12'h001;
					if (cnt == WPH_CYC - 12'h001) begin
						cnt <= 12'h000;
						if (op == OP_RESET3 && step != 2'h2) begin
							step     <= step + 2'h1;
							cyc_addr <= step == 2'h0 ? ADR_UNLOCK2 : ADR_UNLOCK1;
							cyc_data <= step == 2'h0 ? CMD_UNLOCK2 : CMD_RESET;
							state    <= ST_WR_LOW;
						end else if (op == OP_SUSPEND) begin
							state <= ST_SUSP_WAIT;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_SUSP_WAIT: begin
					// no status read is valid until the device has halted
					cnt <= cnt + 12'h001;
					if (cnt == SUSP_CYC - 12'h001) begin
						state <= ST_IDLE;
					end
				end
				ST_RD_LOW: begin
					cnt <= cnt + 12'h001;
					if (cnt == RC_CYC - 12'h001) begin
						cnt   <= 12'h000;
						state <= ST_RD_HIGH;
					end
				end
				ST_RD_HIGH: begin
					// output enable released between reads so toggles can show
					cnt <= cnt + 12'h001;
					if (cnt == OEH_CYC - 12'h001) begin
						cnt   <= 12'h000;
						state <= (op == OP_POLL && !done) ? ST_RD_LOW : ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// status evaluation of each completed read
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata           <= 16'h0000;
			done            <= 1'b0;
			timed_out       <= 1'b0;
			aborted         <= 1'b0;
			toggle_two_seen <= 1'b0;
			poll_first      <= 1'b1;
			poll_prev6      <= 1'b0;
			poll_prev2      <= 1'b0;
			dq5_seen        <= 1'b0;
		end else if (start) begin
			done            <= 1'b0;
			timed_out       <= 1'b0;
			aborted         <= 1'b0;
			toggle_two_seen <= 1'b0;
			poll_first      <= 1'b1;
			dq5_seen        <= 1'b0;
		end else if (state == ST_RD_LOW && cnt == RC_CYC - 12'h001) begin
			rdata      <= dq_s2;
			poll_prev6 <= dq_s2[BIT_TOGGLE_ONE];
			poll_prev2 <= dq_s2[BIT_TOGGLE_TWO];
			poll_first <= 1'b0;
			if (op != OP_POLL) begin
				done <= 1'b1;
			end else if (!poll_first) begin
				if (dq_s2[BIT_TOGGLE_TWO] != poll_prev2) begin
					toggle_two_seen <= 1'b1;
				end
				if (dq_s2[BIT_TOGGLE_ONE] == poll_prev6) begin
					// toggling stopped: finished, or suspended; this read already holds the data, no further read
					done <= 1'b1;
				end else if (dq_s2[BIT_BUFFER_ABORT]) begin
					aborted <= 1'b1;
					done    <= 1'b1;
				end else if (dq_s2[BIT_TIMEOUT]) begin
					// toggle may stop just as the timeout bit rises: check twice
					if (dq5_seen) begin
						timed_out <= 1'b1;
						done      <= 1'b1;
					end
					dq5_seen   <= 1'b1;
					poll_first <= 1'b1;
				end
			end
		end else if (state == ST_WR_HIGH && cnt == WPH_CYC - 12'h001
			&& !(op == OP_RESET3 && step != 2'h2) && op != OP_SUSPEND) begin
			done <= 1'b1;
		end else if (state == ST_SUSP_WAIT && cnt == SUSP_CYC - 12'h001) begin
			done <= 1'b1;
		end
	end

	always_comb begin
		flash_o.addr   = cyc_addr;
		flash_o.ce_n   = !(state == ST_WR_LOW || state == ST_WR_HIGH || state == ST_RD_LOW);
		flash_o.oe_n   = state != ST_RD_LOW;
		flash_o.we_n   = state != ST_WR_LOW;
		flash_o.dq     = cyc_data;
		flash_o.dq_oe  = state == ST_WR_LOW || state == ST_WR_HIGH;
		flash_o.acc_hv = accel_en;
	end
endmodule : flsw_host

// ==== bench/flsw_host_checker.sv ====
// port assertions for the flash host controller
`timescale 1ns/1ps
module flsw_host_checker import flsw_pkg::*; (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  s_axi_awaddr_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0]  s_axi_wstrb_i,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [7:0]  s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire flsw_pins_t  flash_o,
	input wire logic [15:0] flash_dq_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |=> ##1 s_axi_bvalid_o) else $error("write answer late");
	a_bvalid_clear: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("bvalid stuck");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_rvalid_clear: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("rvalid stuck");
	a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while answering");
	a_aw_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while answering");
	a_write_strobe: assert property ($fell(flash_o.we_n) |-> !flash_o.ce_n && flash_o.dq_oe
		##1 (!flash_o.we_n && !flash_o.ce_n && flash_o.dq_oe)[*8]
		##1 (flash_o.we_n && !flash_o.ce_n)) else $error("write strobe width");
	a_read_strobe: assert property ($fell(flash_o.oe_n) |-> !flash_o.dq_oe && !flash_o.ce_n
		##19 !flash_o.oe_n ##1 flash_o.oe_n) else $error("read strobe width");
	a_read_gap: assert property ($rose(flash_o.oe_n) |-> flash_o.oe_n[*5])
		else $error("output enable gap short");
endmodule : flsw_host_checker

// ==== bench/flsw_flash_model.sv ====
// behavioural flash device answering command writes and status reads
`timescale 1ns/1ps
module flsw_flash_model import flsw_pkg::*; (
	input  wire flsw_pins_t pins_i,
	output logic [15:0]     dq_o
);
	int          busy_n = 0;
	int          unlock = 0;
	int          pgm_n  = 0;
	logic        esel   = 1'b0;
	logic        esusp  = 1'b0;
	logic        tog2   = 1'b0;
	logic        late;
	logic        susp   = 1'b0;
	logic        abort  = 1'b0;
	logic        tmo    = 1'b0;
	logic        tog    = 1'b0;
	logic        busy;
	logic [15:0] arr    = 16'h0000;
	logic [15:0] rd     = 16'h0000;
	logic [15:0] cmd    = 16'h0000;
	logic [22:0] adr    = 23'h000000;
	wire         wr_n   = pins_i.ce_n | pins_i.we_n;
	wire         rd_n   = pins_i.ce_n | pins_i.oe_n;
	// released bus shows the inverse of the last word, never a stale copy
	assign dq_o = rd_n ? ~rd : rd;
	always @(posedge wr_n) begin
		cmd = pins_i.dq;
		adr = pins_i.addr;
		if (cmd == CMD_SUSPEND) susp = 1'b1;
		if (cmd == CMD_RESUME) susp = 1'b0;
		// flags clear only through the whole three-write run
		// command runs decode while suspended as well
		if (cmd == CMD_UNLOCK1 && adr == ADR_UNLOCK1) unlock = 1;
		else if (unlock == 1 && cmd == CMD_UNLOCK2 && adr == ADR_UNLOCK2) unlock = 2;
		else if (unlock == 2 && cmd == CMD_RESET && adr == ADR_UNLOCK1) begin
			abort = 1'b0;
			tmo = 1'b0;
			unlock = 0;
		end else unlock = 0;
	end
	always @(negedge rd_n) begin
		// erase work halts in erase suspend; a program started there still runs
		busy = ((busy_n > 0 && !esusp) || pgm_n > 0 || abort || tmo) && !susp;
		// last busy read, with busy_n and pgm_n summing to one, already shows true data on the poll bit unless esel
		late = busy && busy_n + pgm_n == 1 && !esel;
		if (busy) begin
			tog = ~tog;
			if (pgm_n > 0) pgm_n = pgm_n - 1;
			else if (busy_n > 0) busy_n = busy_n - 1;
		end
		if (esel) tog2 = ~tog2;
		rd = {arr[15:8], esel ? !busy : arr[7] ^ (busy && !late), tog, tmo, arr[4:3],
			esel ? tog2 : arr[2], abort, arr[0]};
	end
endmodule : flsw_flash_model

// ==== bench/flash_suspend_and_write_status_test.sv ====
// self-checking bench for the flash suspend and status host controller
`timescale 1ns/1ps
module flash_suspend_and_write_status_test import flsw_pkg::*;;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  s_axi_awaddr_i = 8'h00;
	logic        s_axi_awvalid_i = 1'b0;
	logic        s_axi_awready_o;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hF;
	logic        s_axi_wvalid_i = 1'b0;
	logic        s_axi_wready_o;
	logic [1:0]  s_axi_bresp_o;
	logic        s_axi_bvalid_o;
	logic        s_axi_bready_i = 1'b0;
	logic [7:0]  s_axi_araddr_i = 8'h00;
	logic        s_axi_arvalid_i = 1'b0;
	logic        s_axi_arready_o;
	logic [31:0] s_axi_rdata_o;
	logic [1:0]  s_axi_rresp_o;
	logic        s_axi_rvalid_o;
	logic        s_axi_rready_i = 1'b0;
	flsw_pins_t  flash_o;
	logic [15:0] flash_dq_i;
	int          mismatches = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [31:0] st;
	int          t0;
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;
	flsw_host dut (.*);
	flsw_flash_model mdl (.pins_i(flash_o), .dq_o(flash_dq_i));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic finish_test();
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_t, w_t, b_t;
		logic [1:0] r;
		b_t = 1'b0;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		// ready is judged half a cycle early so the edge itself never races
		while (!b_t) begin
			@(negedge clk_i);
			aw_t = s_axi_awvalid_i && s_axi_awready_o;
			w_t = s_axi_wvalid_i && s_axi_wready_o;
			b_t = s_axi_bvalid_o;
			r = s_axi_bresp_o;
			@(posedge clk_i);
			if (aw_t) s_axi_awvalid_i <= 1'b0;
			if (w_t) s_axi_wvalid_i <= 1'b0;
		end
		s_axi_bready_i <= 1'b0;
		chk("bresp", 32'(er), 32'(r));
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		logic ar_t, v;
		logic [1:0] r;
		v = 1'b0;
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		while (!v) begin
			@(negedge clk_i);
			ar_t = s_axi_arvalid_i && s_axi_arready_o;
			v = s_axi_rvalid_o;
			d = s_axi_rdata_o;
			r = s_axi_rresp_o;
			@(posedge clk_i);
			if (ar_t) s_axi_arvalid_i <= 1'b0;
		end
		s_axi_rready_i <= 1'b0;
		chk("rresp", 32'(er), 32'(r));
	endtask : axi_rd
	task automatic run_op(input logic [2:0] op);
		int n;
		n = 0;
		axi_wr(REG_CTRL, 32'(op), RESP_OKAY);
		do begin
			axi_rd(REG_STATUS, RESP_OKAY, st);
			n++;
		end while (st[0] !== 1'b0 && n < 3000);
		chk("busy", 32'h0, 32'(st[0]));
	endtask : run_op
	task automatic t_basic();
		chk("idle pins", 32'h1C, 32'({flash_o.ce_n, flash_o.oe_n, flash_o.we_n,
			flash_o.dq_oe, flash_o.acc_hv}));
		axi_wr(8'h40, 32'h1, RESP_SLVERR);
		axi_rd(8'h40, RESP_SLVERR, st);
		chk("unmapped data", 32'h0, st);
		axi_wr(REG_ADDR, 32'h0001234, RESP_OKAY);
		axi_wr(REG_WDATA, 32'h00A5, RESP_OKAY);
		run_op(3'd1);
		chk("write addr", 32'h0001234, 32'(mdl.adr));
		chk("write data", 32'h00A5, 32'(mdl.cmd));
	endtask : t_basic
	task automatic t_suspend();
		axi_wr(REG_ADDR, 32'h007ABCD, RESP_OKAY);
		t0 = cyc;
		run_op(3'd3);
		chk("suspend wait", 32'h1, 32'(cyc - t0 >= int'(SUSP_CYC)));
		chk("suspend cmd", 32'(CMD_SUSPEND), 32'(mdl.cmd));
		chk("suspend addr", 32'h007ABCD, 32'(mdl.adr));
		run_op(3'd4);
		run_op(3'd4);
		chk("resume cmd", 32'(CMD_RESUME), 32'(mdl.cmd));
		chk("resumed", 32'h0, 32'(mdl.susp));
	endtask : t_suspend
	task automatic t_status();
		mdl.busy_n = 3;
		mdl.arr = 16'h00A5;
		run_op(3'd5);
		chk("poll status", 32'h22, st & 32'h3E);
		mdl.abort = 1'b1;
		run_op(3'd5);
		chk("abort flag", 32'h1, 32'(st[3]));
		run_op(3'd6);
		chk("abort cleared", 32'h0, 32'(mdl.abort));
		mdl.tmo = 1'b1;
		run_op(3'd5);
		chk("timeout flag", 32'h1, 32'(st[2]));
		chk("timeout poll bit", 32'h0, 32'(st[5]));
		run_op(3'd6);
		chk("timeout cleared", 32'h0, 32'(mdl.tmo));
		axi_wr(REG_ACCEL, 32'h1, RESP_OKAY);
		chk("accel on", 32'h1, 32'(flash_o.acc_hv));
		axi_wr(REG_ACCEL, 32'h0, RESP_OKAY);
		chk("accel off", 32'h0, 32'(flash_o.acc_hv));
	endtask : t_status
	task automatic t_erase();
		mdl.esel = 1'b1;
		mdl.busy_n = 3;
		run_op(3'd2);
		chk("erase poll bit", 32'h0, 32'(st[5]));
		run_op(3'd5);
		chk("erase status", 32'h32, st & 32'h3E);
		mdl.esusp = 1'b1;
		mdl.busy_n = 3;
		run_op(3'd5);
		chk("suspended erase", 32'h32, st & 32'h3E);
		mdl.esel = 1'b0;
		mdl.pgm_n = 2;
		run_op(3'd5);
		chk("suspend program", 32'h22, st & 32'h3E);
		chk("erase held", 32'h3, 32'(mdl.busy_n));
		mdl.esusp = 1'b0;
		mdl.busy_n = 0;
	endtask : t_erase
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_basic();
		t_suspend();
		t_status();
		t_erase();
		finish_test();
	end
	// whole run needs well under this span even with the long suspend wait
	initial begin
		#200000;
		mismatches++;
		finish_test();
	end
endmodule : flash_suspend_and_write_status_test
bind flsw_host flsw_host_checker chk (.*);
